// file: hdl/crb_defs.svh
`ifndef CRB_DEFS_SVH
`define CRB_DEFS_SVH

// clock and line timing
`define CRB_CLK_PERIOD_NS 100
`define CRB_LINE_RATE_HZ 70000
`define CRB_TIMEOUT_MS 16
`define CRB_TIMEOUT_CYC ((`CRB_TIMEOUT_MS * 1000000) / `CRB_CLK_PERIOD_NS)
`define CRB_BIT_THRESH_CYC ((1000000000 / (2 * `CRB_LINE_RATE_HZ)) / `CRB_CLK_PERIOD_NS)
`define CRB_CNT_W 18

// command recognition
`define CRB_CMD_LEN 6
`define CRB_RDBK_CMD 6'h0d
`define CRB_FIFO_DEPTH 8

// readback stream layout
`define CRB_STREAM_BITS 59
`define CRB_EXIT_EDGE 61
`define CRB_POS_REV 0
`define CRB_POS_CAL 3
`define CRB_POS_WRITTEN 9
`define CRB_POS_LOCK 10
`define CRB_POS_WORDS 11
`define CRB_NUM_WORDS 6
`define CRB_REVISION 3'h5

// config word zero fields, stored byte is word bits 10..3
`define CRB_W0_WIDTH 11
`define CRB_W0_SEL_LSB 0
`define CRB_W0_OSC 3
`define CRB_W0_PRESC_LSB 4
`define CRB_W0_OUTDIV_LSB 6
`define CRB_W0_DRV 9
`define CRB_W0_RSVD 10
`define CRB_W0_STORED_LSB 3

// prescaler divide values by code
`define CRB_PRESC_00 3'h5
`define CRB_PRESC_01 3'h3
`define CRB_PRESC_10 3'h4
`define CRB_PRESC_11 3'h2

`endif

// file: hdl/crb_pkg.sv
package crb_pkg;
  typedef enum logic {crb_normal, crb_readback} crb_mode_t;
endpackage

// file: hdl/crb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module crb_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  // storage, no reset needed on the data itself
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers wrap since depth is a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// file: hdl/crb_readback.sv
// Summary of operation
// RULE1: readback command recognised on serial line
// RULE2: after entry the line acts as clock
// RULE3: first clock loads nonvolatile image in parallel
// RULE4: later clocks put next bit on pin
// RULE5: stream is exactly 59 bits
// RULE6: 61st rising edge restores pin, leaves readback
// RULE7: stream bit 0 leaves first
// RULE8: revision msb first, then calibration word
// RULE9: position 9 shows ever-programmed flag
// RULE10: position 10 shows lock; lock blocks rewrite
// RULE11: words five down to zero, msb first
// RULE12: word zero bit 3 picks oscillator
// RULE13: word zero bits 5:4 give prescale code
// RULE14: prescale code sets divide value
// RULE15: word zero bits 8:6 give output divide
// RULE16: word zero bit 9 picks driver type
// RULE17: select code zero, bit 10 reserved
// RULE18: short high is 0, long high 1
// RULE19: overlong pulse abandons entry sequence
// RULE20: output divide codes 1 through 32
// RULE21: prescale codes 5, 3, 4, 2
`timescale 1ns/1ps
`default_nettype none
`include "crb_defs.svh"
module crb_readback
  import crb_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `CRB_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_config_line,
  input wire logic synth_clock_in,
  input wire logic [47:0] nvm_words,
  input wire logic [5:0] nvm_cal_word,
  input wire logic nvm_written,
  input wire logic nvm_locked,
  output logic clock_output_pin,
  output logic readback_active,
  output logic cmd_fifo_ready,
  output logic bit_dropped,
  output logic oscillator_choice,
  output logic [1:0] prescale_choice,
  output logic [2:0] prescale_divide,
  output logic [2:0] output_divide_choice,
  output logic [5:0] output_divide,
  output logic driver_choice,
  output logic reserved_test_bit,
  output logic [10:0] config_word_zero,
  output logic rewrite_permitted
);
  localparam int CW = `CRB_CNT_W;
  localparam logic [CW-1:0] TIMEOUT = TIMEOUT_CYCLES[CW-1:0];
  localparam logic [CW-1:0] THRESH = CW'(`CRB_BIT_THRESH_CYC);
  localparam logic [5:0] LAST_EDGE = 6'(`CRB_EXIT_EDGE - 1);

  ////////////////////////////////////////////////////////////////////////
  // stream image builder, position index equals shift order

  function automatic logic [`CRB_STREAM_BITS-1:0] stream_image(
    input logic [47:0] words,
    input logic [5:0] cal,
    input logic written,
    input logic locked
  );
    logic [`CRB_STREAM_BITS-1:0] img;
    logic [2:0] rev;
    img = '0;
    rev = `CRB_REVISION;
    for (int i = 0; i < 3; i++) begin
      img[`CRB_POS_REV + i] = rev[2 - i]; // see RULE8
    end
    for (int i = 0; i < 6; i++) begin
      img[`CRB_POS_CAL + i] = cal[5 - i]; // see RULE8
    end
    img[`CRB_POS_WRITTEN] = written; // see RULE9
    img[`CRB_POS_LOCK] = locked; // see RULE10
    // word five first, each msb first
    for (int w = 0; w < `CRB_NUM_WORDS; w++) begin
      for (int b = 0; b < 8; b++) begin
        img[`CRB_POS_WORDS + 8 * w + b] = words[8 * (5 - w) + 7 - b]; // see RULE11
      end
    end
    return img;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detection

  logic line_s1_q;
  logic line_s2_q;
  logic line_s3_q;
  logic rise;
  logic fall;

  // line is asynchronous to ref_clk; s1 only feeds s2
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_s1_q <= 1'b0;
      line_s2_q <= 1'b0;
      line_s3_q <= 1'b0;
    end else begin
      line_s1_q <= serial_config_line;
      line_s2_q <= line_s1_q;
      line_s3_q <= line_s2_q;
    end
  end

  assign rise = line_s2_q && !line_s3_q;
  assign fall = !line_s2_q && line_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // pulse width measurement and time-out

  crb_mode_t mode_q;
  logic [CW-1:0] level_cnt_q;
  logic timed_out;

  // counts cycles since the last edge, saturates at the time-out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level_cnt_q <= '0;
    end else if (rise || fall) begin
      level_cnt_q <= '0;
    end else if (level_cnt_q != TIMEOUT) begin
      level_cnt_q <= level_cnt_q + 1'b1;
    end
  end

  // one-cycle strobe when a high or low pulse runs too long
  assign timed_out = (level_cnt_q == TIMEOUT - 1'b1) && !(rise || fall); // see RULE19

  ////////////////////////////////////////////////////////////////////////
  // bit decode into the command fifo

  logic dec_valid;
  logic dec_bit;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_out_bit;
  logic dropped_q;

  // decide at the falling edge from the high time; half period splits 0.2t from 0.8t
  assign dec_valid = fall && (mode_q == crb_normal) && (level_cnt_q != TIMEOUT);
  assign dec_bit = (level_cnt_q >= THRESH); // see RULE18
  // drain stalls while reading back, so decoded bits wait their turn
  assign fifo_out_ready = (mode_q == crb_normal);
  assign cmd_fifo_ready = fifo_in_ready;

  crb_fifo #(
    .WIDTH(1),
    .DEPTH(`CRB_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(dec_valid),
    .in_ready(fifo_in_ready),
    .in_data(dec_bit),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_bit)
  );

  // a bit lost to a full fifo is flagged for one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dropped_q <= 1'b0;
    end else begin
      dropped_q <= dec_valid && !fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command matcher

  logic [`CRB_CMD_LEN-1:0] cmd_bits_q;
  logic [2:0] cmd_cnt_q;
  logic [`CRB_CMD_LEN-1:0] cmd_next;
  logic cmd_pop;
  logic cmd_hit;

  assign cmd_pop = fifo_out_valid && fifo_out_ready;
  assign cmd_next = {cmd_bits_q[`CRB_CMD_LEN-2:0], fifo_out_bit};
  assign cmd_hit = cmd_pop && (cmd_cnt_q >= 3'(`CRB_CMD_LEN - 1)) && (cmd_next == `CRB_RDBK_CMD); // see RULE1

  // history of recent bits; a time-out throws the partial sequence away
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_bits_q <= '0;
      cmd_cnt_q <= '0;
    end else if (timed_out || cmd_hit) begin
      cmd_bits_q <= '0; // see RULE19
      cmd_cnt_q <= '0;
    end else if (cmd_pop) begin
      cmd_bits_q <= cmd_next;
      if (cmd_cnt_q != 3'(`CRB_CMD_LEN)) begin
        cmd_cnt_q <= cmd_cnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback sequencer, line used as a clock

  logic [5:0] edge_cnt_q;
  logic [`CRB_STREAM_BITS-1:0] shift_q;
  logic rb_bit_q;
  logic pin_q;

  // mode and edge count; the 61st rising edge ends readback
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= crb_normal;
      edge_cnt_q <= '0;
    end else begin
      unique case (mode_q)
        crb_normal: begin
          if (cmd_hit) begin
            mode_q <= crb_readback; // see RULE2
            edge_cnt_q <= '0;
          end
        end
        crb_readback: begin
          if (rise) begin
            if (edge_cnt_q == LAST_EDGE) begin
              mode_q <= crb_normal; // see RULE6
              edge_cnt_q <= '0;
            end else begin
              edge_cnt_q <= edge_cnt_q + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // first edge loads, edges 2..60 shift out the 59 bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      rb_bit_q <= 1'b0;
    end else if (mode_q == crb_readback && rise) begin
      if (edge_cnt_q == 6'h00) begin
        shift_q <= stream_image(nvm_words, nvm_cal_word, nvm_written, nvm_locked); // see RULE3
      end else if (edge_cnt_q != LAST_EDGE) begin
        rb_bit_q <= shift_q[0]; // see RULE4, see RULE7
        shift_q <= {1'b0, shift_q[`CRB_STREAM_BITS-1:1]}; // see RULE5
      end
    end
  end

  // pin carries the stream only while reading back, otherwise the clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (mode_q == crb_readback) begin
      pin_q <= rb_bit_q; // see RULE4
    end else begin
      pin_q <= synth_clock_in; // see RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration word zero decode

  logic [7:0] w0_byte;
  logic [10:0] w0_q;
  logic [2:0] presc_div_q;
  logic [5:0] out_div_q;
  logic rewrite_q;

  // only bits 10..3 are stored; the select code of word zero is all zeros
  assign w0_byte = nvm_words[7:0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      w0_q <= '0;
    end else begin
      w0_q <= {w0_byte, 3'h0}; // see RULE17
    end
  end

  // prescale code to divide value
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc_div_q <= `CRB_PRESC_00;
    end else begin
      unique case (w0_byte[2:1])
        2'h0: presc_div_q <= `CRB_PRESC_00; // see RULE21
        2'h1: presc_div_q <= `CRB_PRESC_01;
        2'h2: presc_div_q <= `CRB_PRESC_10;
        2'h3: presc_div_q <= `CRB_PRESC_11; // see RULE14
      endcase
    end
  end

  // output divide is a power of two; codes above 101 saturate at 32
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_div_q <= 6'h01;
    end else if (w0_byte[5:3] > 3'h5) begin
      out_div_q <= 6'h20;
    end else begin
      out_div_q <= 6'h01 << w0_byte[5:3]; // see RULE20
    end
  end

  // a locked memory refuses rewrites
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rewrite_q <= 1'b0;
    end else begin
      rewrite_q <= !nvm_locked; // see RULE10
    end
  end

  assign oscillator_choice = w0_q[`CRB_W0_OSC]; // see RULE12
  assign prescale_choice = w0_q[`CRB_W0_PRESC_LSB +: 2]; // see RULE13
  assign prescale_divide = presc_div_q;
  assign output_divide_choice = w0_q[`CRB_W0_OUTDIV_LSB +: 3]; // see RULE15
  assign output_divide = out_div_q;
  assign driver_choice = w0_q[`CRB_W0_DRV]; // see RULE16
  assign reserved_test_bit = w0_q[`CRB_W0_RSVD];
  assign config_word_zero = w0_q;
  assign rewrite_permitted = rewrite_q;
  assign clock_output_pin = pin_q;
  assign readback_active = (mode_q == crb_readback);
  assign bit_dropped = dropped_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [`CRB_STREAM_BITS-1:0] img_q;

  // helper copy of the loaded image for position checks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      img_q <= '0;
    end else if (mode_q == crb_readback && rise && edge_cnt_q == 6'h00) begin
      img_q <= stream_image(nvm_words, nvm_cal_word, nvm_written, nvm_locked);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_cmd_entry: assert property (cmd_hit |=> mode_q == crb_readback) // see RULE1
    else $error("readback not entered after command");
  chk_first_load: assert property (mode_q == crb_readback && rise && edge_cnt_q == 6'h00
    |=> shift_q == img_q && edge_cnt_q == 6'h01) // see RULE3
    else $error("first edge did not load image");
  chk_stream_order: assert property (mode_q == crb_readback && rise && edge_cnt_q >= 6'h01
    && edge_cnt_q < LAST_EDGE |=> rb_bit_q == img_q[$past(edge_cnt_q) - 6'h01]) // see RULE7
    else $error("stream bit out of order");
  chk_first_rev: assert property (mode_q == crb_readback && rise && edge_cnt_q == 6'h01
    |=> rb_bit_q == `CRB_REVISION >> 2 ##1 pin_q == rb_bit_q) // see RULE8
    else $error("revision msb not first");
  chk_exit_edge: assert property (mode_q == crb_readback && rise && edge_cnt_q == LAST_EDGE
    |=> mode_q == crb_normal ##1 pin_q == $past(synth_clock_in)) // see RULE6
    else $error("readback did not end on 61st edge");
  chk_no_early_exit: assert property (mode_q == crb_readback && edge_cnt_q != LAST_EDGE
    |=> mode_q == crb_readback) // see RULE5
    else $error("readback left early");
  chk_decode_width: assert property (dec_valid && level_cnt_q < THRESH |-> !dec_bit) // see RULE18
    else $error("short pulse decoded as one");
  chk_timeout_flush: assert property (timed_out && mode_q == crb_normal |=> cmd_cnt_q == 3'h0) // see RULE19
    else $error("time-out kept partial command");
  chk_presc_two: assert property (w0_byte[2:1] == 2'h3 |=> prescale_divide == 3'h2) // see RULE21
    else $error("prescale code 11 not divide by 2");
  chk_outdiv_pow: assert property (output_divide_choice == 3'h4 |-> output_divide == 6'h10) // see RULE20
    else $error("output divide code 100 not 16");
  chk_lock_block: assert property (nvm_locked |=> !rewrite_permitted) // see RULE10
    else $error("locked memory still rewritable");
  chk_osc_field: assert property (1'b1 |=> oscillator_choice == $past(nvm_words[0])) // see RULE12
    else $error("oscillator choice not from word zero bit 3");

  cov_enter: cover property (cmd_hit);
  cov_full_stream: cover property (mode_q == crb_readback && rise && edge_cnt_q == LAST_EDGE);
  cov_timeout: cover property (timed_out && cmd_cnt_q != 3'h0);
  cov_fifo_full: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

// file: dv/crb_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module crb_ctl_model #(
  parameter int BIT_CYC = 143,
  parameter int CLK_HALF = 4
) (
  input wire logic ref_clk,
  output var logic serial_config_line
);
  // line rests low between frames, the controller makes no free-running clock
  initial serial_config_line = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // one level for n reference cycles, changed just after an edge
  task automatic hold(input logic lvl, input int n);
    @(posedge ref_clk);
    #1 serial_config_line = lvl;
    repeat (n - 1) @(posedge ref_clk);
  endtask

  // width-coded bit, stretch lengthens the low tail to force a time-out
  task automatic send_bit(input logic b, input int stretch);
    hold(1'b1, b ? (BIT_CYC * 4) / 5 : BIT_CYC / 5);
    hold(1'b0, (b ? BIT_CYC / 5 : (BIT_CYC * 4) / 5) + stretch);
  endtask

  // command bits oldest first, each pulse well under the time-out
  task automatic send_cmd(input logic [5:0] c);
    for (int i = 5; i >= 0; i--) begin
      send_bit(c[i], 0);
    end
  endtask

  // one shift clock, the caller supplies all 61 of them
  task automatic clk_pulse();
    hold(1'b1, CLK_HALF);
    hold(1'b0, CLK_HALF);
  endtask
endmodule
`default_nettype wire

// file: dv/test_config_readback_and_word0.sv
`timescale 1ns/1ps
`default_nettype none
`include "crb_defs.svh"
module test_config_readback_and_word0;
  logic ref_clk, rst, serial_config_line, synth_clock_in, nvm_written, nvm_locked;
  logic [47:0] nvm_words;
  logic [5:0] nvm_cal_word;
  logic clock_output_pin, readback_active, cmd_fifo_ready, bit_dropped, oscillator_choice;
  logic driver_choice, reserved_test_bit, rewrite_permitted;
  logic [1:0] prescale_choice;
  logic [2:0] prescale_divide, output_divide_choice;
  logic [5:0] output_divide;
  logic [10:0] config_word_zero;
  int miscompares = 0;
  int n_tests = 0;
  logic [2:0] pdiv [4] = '{3'h5, 3'h3, 3'h4, 3'h2};

  ////////////////////////////////////////////////////////////////////////////
  // short time-out so the abandon case stays cheap
  crb_readback #(.TIMEOUT_CYCLES(2000)) crb_readback_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .serial_config_line(serial_config_line),
    .synth_clock_in(synth_clock_in),
    .nvm_words(nvm_words),
    .nvm_cal_word(nvm_cal_word),
    .nvm_written(nvm_written),
    .nvm_locked(nvm_locked),
    .clock_output_pin(clock_output_pin),
    .readback_active(readback_active),
    .cmd_fifo_ready(cmd_fifo_ready),
    .bit_dropped(bit_dropped),
    .oscillator_choice(oscillator_choice),
    .prescale_choice(prescale_choice),
    .prescale_divide(prescale_divide),
    .output_divide_choice(output_divide_choice),
    .output_divide(output_divide),
    .driver_choice(driver_choice),
    .reserved_test_bit(reserved_test_bit),
    .config_word_zero(config_word_zero),
    .rewrite_permitted(rewrite_permitted)
  );
  crb_ctl_model #(.BIT_CYC(143), .CLK_HALF(4)) crb_ctl_model_i (
    .ref_clk(ref_clk),
    .serial_config_line(serial_config_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  task automatic conclude();
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // pin must track the synthesizer level one cycle late in normal mode
  task automatic pin_follows();
    #1 synth_clock_in = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check(clock_output_pin, 0, "pin low");
    synth_clock_in = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check(clock_output_pin, 1, "pin high");
  endtask

  // full readback, expected stream built msb first from the stored image
  task automatic run_rb(input logic [47:0] w, input logic [5:0] cal, input logic wr, input logic lk);
    logic [58:0] cat;
    int k;
    cat = {`CRB_REVISION, cal, wr, lk, w};
    @(posedge ref_clk);
    #1 nvm_words = w;
    nvm_cal_word = cal;
    nvm_written = wr;
    nvm_locked = lk;
    synth_clock_in = 1'b1;
    crb_ctl_model_i.send_cmd(6'h0d);
    k = 0;
    #1;
    while (readback_active !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #1 k++;
    end
    check(readback_active, 1, "entry");
    for (int e = 1; e <= 61; e++) begin
      crb_ctl_model_i.clk_pulse();
      #1;
      if (e >= 2 && e <= 60) check(clock_output_pin, cat[60-e], "stream");
      if (e == 60) check(readback_active, 1, "early exit");
    end
    check(readback_active, 0, "no exit");
    pin_follows();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, the whole sequence needs about 7100 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    synth_clock_in = 1'b0;
    nvm_words = 48'h0;
    nvm_cal_word = 6'h0;
    nvm_written = 1'b0;
    nvm_locked = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 check(prescale_divide, 5, "rst presc");
    check(output_divide, 1, "rst outdiv");
    check(readback_active, 0, "rst mode");
    rst = 1'b0;
    pin_follows();
    // every stored byte of word zero, lock flag alternating
    for (int b = 0; b < 256; b++) begin
      @(posedge ref_clk);
      #1 nvm_words[7:0] = b[7:0];
      nvm_locked = b[0];
      @(posedge ref_clk);
      #1 check(oscillator_choice, b[0], "osc");
      check(prescale_choice, b[2:1], "presc code");
      check(prescale_divide, pdiv[b[2:1]], "presc div");
      check(output_divide_choice, b[5:3], "outdiv code");
      check(output_divide, (b[5:3] > 5) ? 32 : (1 << b[5:3]), "outdiv");
      check(driver_choice, b[6], "driver");
      check(reserved_test_bit, b[7], "reserved");
      check(config_word_zero, {b[7:0], 3'b000}, "word zero");
      check(rewrite_permitted, !b[0], "rewrite");
    end
    // three bits, a stalled low, then a tail that would complete the command
    crb_ctl_model_i.send_bit(1'b0, 0);
    crb_ctl_model_i.send_bit(1'b0, 0);
    crb_ctl_model_i.send_bit(1'b1, 2100);
    crb_ctl_model_i.send_bit(1'b1, 0);
    crb_ctl_model_i.send_bit(1'b0, 0);
    crb_ctl_model_i.send_bit(1'b1, 0);
    repeat (20) @(posedge ref_clk);
    #1 check(readback_active, 0, "timeout");
    run_rb(48'ha5c3_0f96_e718, 6'h2d, 1'b1, 1'b0);
    run_rb(48'h5a3c_f069_18e7, 6'h12, 1'b0, 1'b1);
    // non-matching bits through the command buffer, watched from the pins every cycle
    fork
      crb_ctl_model_i.send_cmd(6'h2c);
      repeat (900) begin
        @(posedge ref_clk);
        #1 check(cmd_fifo_ready, 1, "fifo ready");
        check(bit_dropped, 0, "bit dropped");
        check(readback_active, 0, "false entry");
        check(clock_output_pin, 1, "pin normal");
      end
    join
    check(readback_active, 0, "no match");
    conclude();
  end
endmodule
`default_nettype wire
